// >>> logic/fdl_fault_ctrl.sv
// fdl_fault_ctrl: fault delay selector, input overcurrent threshold registers,
// threshold comparator and the shutdown/restart sequencer.
// assumes a synchronous register port driven by the bus front end and a
// measured input current in the same linear units as the threshold.
`default_nettype none

module fdl_fault_ctrl
  import fdl_pkg::*;
#(
  parameter int CYC_PER_MS_P = CYC_PER_MS,
  parameter int MEAS_W = 16
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [15:0] reg_wdata_in,
  output logic [15:0] reg_rdata_out,
  output logic reg_ack_out,
  output logic reg_err_out,
  input wire logic [MEAS_W-1:0] iin_meas_in,
  output logic oc_fault_out,
  output logic output_enable_out
);

  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_HOLD = 3'b010,
    ST_OFF = 3'b100
  } fdl_state_t;

  typedef struct packed {
    fdl_state_t state;
    logic [UV_REG_W-1:0] uv_reaction;
    logic [MANT_W-1:0] mantissa;
    logic [15:0] exp_reg;
    logic [15:0] rdata;
    logic ack;
    logic err;
    logic oc_flag;
    logic out_en;
    logic tmr_start;
    logic [MS_W-1:0] tmr_ms;
  } fdl_ctrl_t;

  fdl_ctrl_t cur_ff;
  fdl_ctrl_t nxt_ff;
  logic tmr_done;
  logic [EXP_W-1:0] exp_now;
  logic [DLY_SEL_W-1:0] dly_sel;
  logic [CMP_W-1:0] meas_side;
  logic [CMP_W-1:0] thr_side;
  logic exp_neg;
  logic [EXP_W-1:0] exp_mag;

  // ==========================================================================
  // decoded fields and scaled comparison operands
  // ==========================================================================
  // exponent lives in the separate exponent register; the threshold only mirrors it
  assign exp_now = cur_ff.exp_reg[EXPREG_EXP_LSB +: EXP_W];
  assign dly_sel = cur_ff.uv_reaction[DLY_SEL_LSB +: DLY_SEL_W];
  assign exp_neg = exp_now[EXP_W-1];
  assign exp_mag = exp_neg ? EXP_W'(-exp_now) : exp_now;
  // shift the smaller side instead of dividing, so negative exponents stay exact
  assign meas_side = exp_neg ? (CMP_W'(iin_meas_in) << exp_mag) : CMP_W'(iin_meas_in);
  assign thr_side = exp_neg ? CMP_W'(cur_ff.mantissa) : (CMP_W'(cur_ff.mantissa) << exp_mag);

  // ==========================================================================
  // next state: register port, comparator, sequencer
  // ==========================================================================
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.ack = 1'b0;
    nxt_ff.err = 1'b0;
    nxt_ff.tmr_start = 1'b0;
    nxt_ff.oc_flag = meas_side > thr_side;
    // write wins when both strobes arrive in one cycle
    // register writes; threshold exponent bits are dropped on write
    if (reg_wr_in) begin
      nxt_ff.ack = 1'b1;
      unique case (reg_addr_in)
        UV_REACTION_ADDR: nxt_ff.uv_reaction = reg_wdata_in[UV_REG_W-1:0];
        OC_THRESHOLD_ADDR: nxt_ff.mantissa = reg_wdata_in[MANT_W-1:0];
        EXPONENT_ADDR: nxt_ff.exp_reg = reg_wdata_in;
        default: nxt_ff.err = 1'b1;
      endcase
    end else if (reg_rd_in) begin
      nxt_ff.ack = 1'b1;
      unique case (reg_addr_in)
        UV_REACTION_ADDR: nxt_ff.rdata = {8'h00, cur_ff.uv_reaction};
        OC_THRESHOLD_ADDR: nxt_ff.rdata = {exp_now, cur_ff.mantissa};
        EXPONENT_ADDR: nxt_ff.rdata = cur_ff.exp_reg;
        default: begin
          nxt_ff.rdata = 16'h0000;
          nxt_ff.err = 1'b1;
        end
      endcase
    end
    // sequencer; retries never run out since the retry field lives elsewhere
    // delay code is taken as each delay starts; a rewrite applies to the next one
    unique case (cur_ff.state)
      ST_RUN: begin
        nxt_ff.out_en = 1'b1;
        if (cur_ff.oc_flag) begin
          nxt_ff.state = ST_HOLD;
          nxt_ff.tmr_start = 1'b1;
          nxt_ff.tmr_ms = MS_W'(DLY1_BASE_MS << dly_sel);
        end
      end
      ST_HOLD: begin
        // a timer left running by an aborted hold may finish in the cycle of a
        // fresh start; that stale done must not cut the new first delay short
        if (!cur_ff.oc_flag) begin
          nxt_ff.state = ST_RUN;  // fault went away before the first delay ran out
        end else if (tmr_done && !cur_ff.tmr_start) begin
          nxt_ff.state = ST_OFF;
          nxt_ff.out_en = 1'b0;
          nxt_ff.tmr_start = 1'b1;
          nxt_ff.tmr_ms = DLY2_MS[dly_sel];
        end
      end
      // a lasting fault keeps cycling from off through run back to hold and off
      ST_OFF: begin
        nxt_ff.out_en = 1'b0;
        if (tmr_done) begin
          nxt_ff.state = ST_RUN;
          nxt_ff.out_en = 1'b1;
        end
      end
      default: begin
        nxt_ff.state = ST_RUN;
        nxt_ff.out_en = 1'b1;
      end
    endcase
  end

  // ==========================================================================
  // state register
  // ==========================================================================
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cur_ff <= '{state: ST_RUN, uv_reaction: UV_REACTION_RST, mantissa: MANTISSA_RST,
                  exp_reg: EXPONENT_REG_RST, rdata: 16'h0000, ack: 1'b0, err: 1'b0,
                  oc_flag: 1'b0, out_en: 1'b0, tmr_start: 1'b0, tmr_ms: 12'h000};
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // ==========================================================================
  // delay timer
  // ==========================================================================
  fdl_ms_timer #(
    .CYC_PER_MS_P(CYC_PER_MS_P)
  ) u_timer (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .start_in(cur_ff.tmr_start),
    .ms_in(cur_ff.tmr_ms),
    .done_out(tmr_done)
  );

  assign reg_rdata_out = cur_ff.rdata;
  assign reg_ack_out = cur_ff.ack;
  assign reg_err_out = cur_ff.err;
  assign oc_fault_out = cur_ff.oc_flag;
  assign output_enable_out = cur_ff.out_en;

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);

  // register port
  exp_readback_a: assert property (reg_rd_in && !reg_wr_in && reg_addr_in == OC_THRESHOLD_ADDR |=>
    reg_rdata_out == {$past(exp_now), $past(cur_ff.mantissa)}) else $error("threshold readback wrong");
  exp_readonly_a: assert property (reg_wr_in && reg_addr_in == OC_THRESHOLD_ADDR |=>
    $stable(cur_ff.exp_reg)) else $error("threshold write touched exponent");
  mant_high_a: assert property (reg_wr_in && reg_addr_in == OC_THRESHOLD_ADDR |=>
    cur_ff.mantissa[10:8] == $past(reg_wdata_in[10:8])) else $error("upper mantissa not stored");
  mant_low_a: assert property (reg_wr_in && reg_addr_in == OC_THRESHOLD_ADDR |=>
    cur_ff.mantissa[7:0] == $past(reg_wdata_in[7:0])) else $error("lower mantissa not stored");
  // comparator, one cycle behind the measurement
  oc_pos_exp_a: assert property (exp_now == 5'h00 && 32'(iin_meas_in) > 32'(cur_ff.mantissa) |=>
    oc_fault_out) else $error("overcurrent missed at zero exponent");
  oc_scale_a: assert property (exp_now == 5'h01 && 32'(iin_meas_in) <= 32'(cur_ff.mantissa) * 2 |=>
    !oc_fault_out) else $error("overcurrent raised below scaled threshold");
  oc_neg_exp_a: assert property (exp_now == 5'h1F && 32'(iin_meas_in) * 2 > 32'(cur_ff.mantissa) |=>
    oc_fault_out) else $error("overcurrent missed at negative exponent");
  // sequencer
  dly1_pick_a: assert property (cur_ff.state == ST_RUN && cur_ff.oc_flag |=>
    cur_ff.tmr_start && cur_ff.tmr_ms == 12'(10 << $past(dly_sel))) else $error("first delay wrong");
  dly2_pick_a: assert property (cur_ff.state == ST_HOLD && cur_ff.oc_flag && tmr_done && !cur_ff.tmr_start |=>
    cur_ff.tmr_ms == DLY2_MS[$past(dly_sel)] && !output_enable_out) else $error("second delay wrong");
  off_state_a: assert property (cur_ff.state == ST_OFF |-> !output_enable_out)
    else $error("output on while shut down");
  // the output stays on for the whole first delay
  hold_output_on_a: assert property (cur_ff.state == ST_HOLD |-> output_enable_out)
    else $error("output dropped before first delay ran out");
  // a finished second delay always brings the output back
  restart_on_a: assert property (cur_ff.state == ST_OFF && tmr_done |=> output_enable_out)
    else $error("output not restored after second delay");

  // main scenarios
  shutdown_c: cover property (cur_ff.state == ST_HOLD ##1 cur_ff.state == ST_OFF);
  restart_c: cover property (cur_ff.state == ST_OFF ##1 cur_ff.state == ST_RUN);
  abort_c: cover property (cur_ff.state == ST_HOLD ##1 cur_ff.state == ST_RUN);
  neg_exp_c: cover property (exp_neg && oc_fault_out);
  max_code_off_c: cover property (cur_ff.state == ST_OFF && (&dly_sel));

endmodule  // fdl_fault_ctrl

`default_nettype wire

// >>> pkg/fdl_pkg.sv
// fdl_pkg: register offsets, field layouts, delay tables and timing constants
// for the fault delay and input current limit block.
// assumes a single 40 MHz clock domain; times are kept in ms as printed.
`default_nettype none

package fdl_pkg;

  // ==========================================================================
  // register offsets (management bus command codes)
  // ==========================================================================
  localparam logic [15:0] UV_REACTION_ADDR = 16'h005A;
  localparam logic [15:0] OC_THRESHOLD_ADDR = 16'h005B;
  localparam logic [15:0] EXPONENT_ADDR = 16'hFE39;

  // ==========================================================================
  // field layouts
  // ==========================================================================
  localparam int DLY_SEL_LSB = 0;
  localparam int DLY_SEL_W = 3;
  localparam int UV_REG_W = 8;
  localparam int MANT_W = 11;
  localparam int EXP_W = 5;
  localparam int THR_EXP_LSB = 11;
  localparam int EXPREG_EXP_LSB = 6;
  localparam int MS_W = 12;
  localparam int CMP_W = 32;

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic [7:0] UV_REACTION_RST = 8'h00;
  localparam logic [10:0] MANTISSA_RST = 11'h7FF;
  localparam logic [15:0] EXPONENT_REG_RST = 16'h0000;

  // ==========================================================================
  // delay times in ms
  // ==========================================================================
  localparam logic [11:0] DLY1_BASE_MS = 12'h000A;  // 10 ms, doubled per code step
  localparam logic [7:0][11:0] DLY2_MS = {
    12'h0A2C,  // code 7: 2604 ms
    12'h08DC,  // code 6: 2268 ms
    12'h078C,  // code 5: 1932 ms
    12'h063C,  // code 4: 1596 ms
    12'h04EC,  // code 3: 1260 ms
    12'h039C,  // code 2: 924 ms
    12'h022E,  // code 1: 558 ms
    12'h00FC   // code 0: 252 ms
  };

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int CLK_HZ = 40000000;
  localparam int MS_PER_S = 1000;
  localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;

endpackage : fdl_pkg

`default_nettype wire

// >>> logic/fdl_ms_timer.sv
// fdl_ms_timer: one-shot millisecond timer with a cycle prescaler.
// assumes start_in is a one-cycle pulse; a new start restarts the count.
`default_nettype none

module fdl_ms_timer
  import fdl_pkg::*;
#(
  parameter int CYC_PER_MS_P = CYC_PER_MS
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic start_in,
  input wire logic [MS_W-1:0] ms_in,
  output logic done_out
);

  typedef struct packed {
    logic busy;
    logic done;
    logic [MS_W-1:0] ms_left;
    logic [31:0] pre;
  } fdl_tmr_t;

  fdl_tmr_t cur_ff;
  fdl_tmr_t nxt_ff;

  // ==========================================================================
  // next state: prescale cycles to ms ticks, count ms down
  // ==========================================================================
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.done = 1'b0;
    if (start_in) begin
      nxt_ff.busy = 1'b1;
      nxt_ff.ms_left = ms_in;
      nxt_ff.pre = 32'(CYC_PER_MS_P - 1);
    end else if (cur_ff.busy) begin
      if (cur_ff.pre == 32'h0000_0000) begin
        nxt_ff.pre = 32'(CYC_PER_MS_P - 1);
        if (cur_ff.ms_left <= 12'h001) begin  // zero ms treated as one
          nxt_ff.busy = 1'b0;
          nxt_ff.done = 1'b1;
        end else begin
          nxt_ff.ms_left = cur_ff.ms_left - 12'h001;
        end
      end else begin
        nxt_ff.pre = cur_ff.pre - 32'h0000_0001;
      end
    end
  end

  // ==========================================================================
  // state register
  // ==========================================================================
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign done_out = cur_ff.done;

  // ==========================================================================
  // checks
  // ==========================================================================
  done_single_a: assert property (@(posedge clk_in) disable iff (reset_in)
    cur_ff.done |=> !cur_ff.done) else $error("timer done lasted more than one cycle");

endmodule  // fdl_ms_timer

`default_nettype wire

// >>> verif/fdl_host_model.sv
// fdl_host_model: behavioural host that issues register reads and writes.
// assumes the strobe port of fdl_fault_ctrl; drives just after the falling edge.
`default_nettype none

module fdl_host_model
  import fdl_pkg::*;
(
  input wire logic clk_in,
  input wire logic [15:0] reg_rdata_in,
  input wire logic reg_ack_in,
  input wire logic reg_err_in,
  output logic [15:0] reg_addr_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [15:0] reg_wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // idle bus
  // ==========================================================================
  initial begin
    reg_addr_out = 16'h0000;
    reg_wr_out = 1'h0;
    reg_rd_out = 1'h0;
    reg_wdata_out = 16'h0000;
  end

  // one strobe cycle per access; answer taken with the ack
  task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] data,
                        output logic [15:0] rd, output logic ackd, output logic errd);
    @(negedge clk_in);
    reg_addr_out = addr;
    reg_wdata_out = data;
    reg_wr_out = wr;
    reg_rd_out = !wr;
    @(posedge clk_in);
    @(negedge clk_in);
    reg_wr_out = 1'h0;
    reg_rd_out = 1'h0;
    // released lines show inverted values, so stale data cannot pass unseen
    reg_addr_out = ~addr;
    reg_wdata_out = ~data;
    rd = reg_rdata_in;
    ackd = reg_ack_in;
    errd = reg_err_in;
  endtask
endmodule // fdl_host_model

`default_nettype wire

// >>> verif/testbench.sv
// testbench: random and corner tests of the fault delay and current limit block.
// assumes fdl_host_model as register host; timer shortened to 4 cycles per ms.
`default_nettype none

module testbench
  import fdl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int CPM = 4;
  // second delay in ms per code: 252 558 924 1260 1596 1932 2268 2604
  localparam logic [11:0] D2_TAB [8] = '{12'h0fc, 12'h22e, 12'h39c, 12'h4ec, 12'h63c, 12'h78c, 12'h8dc, 12'ha2c};
  logic clk_in, reset_in, reg_wr, reg_rd, reg_ack, reg_err, oc_fault_out, output_enable_out;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, iin_meas_in, w, x, meas;
  logic [10:0] m;
  int miscompares, num_checks, e, n, bnd;

  // ==========================================================================
  // clock, design and host
  // ==========================================================================
  initial begin
    clk_in = 1'h0;
    forever #12.5 clk_in = ~clk_in;
  end

  fdl_fault_ctrl #(.CYC_PER_MS_P(CPM), .MEAS_W(16)) dut_u (.clk_in(clk_in), .reset_in(reset_in),
    .reg_addr_in(reg_addr), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_wdata_in(reg_wdata),
    .reg_rdata_out(reg_rdata), .reg_ack_out(reg_ack), .reg_err_out(reg_err), .iin_meas_in(iin_meas_in),
    .oc_fault_out(oc_fault_out), .output_enable_out(output_enable_out));

  fdl_host_model host_u (.clk_in(clk_in), .reg_rdata_in(reg_rdata), .reg_ack_in(reg_ack),
    .reg_err_in(reg_err), .reg_addr_out(reg_addr), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd),
    .reg_wdata_out(reg_wdata));

  // ==========================================================================
  // expectations and checks
  // ==========================================================================
  // threshold compare done in 32 bits so no shift overflows
  function automatic logic exp_fault(input logic [15:0] v, input logic [10:0] mt, input int ex);
    if (ex >= 0) return 32'(v) > (32'(mt) << ex);
    return (32'(v) << -ex) > 32'(mt);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // delays get a small window for the sequencer's own pipeline cycles
  task automatic chk_rng(input int got, input int lo, input int hi);
    num_checks++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, lo);
    end
  endtask

  task automatic reg_op(input logic wr, input logic [15:0] addr, input logic [15:0] data,
                        input logic [15:0] exp_rd, input logic exp_err);
    logic [15:0] rd;
    logic ak, er;
    host_u.access(wr, addr, data, rd, ak, er);
    chk(32'({ak, er}), 32'({1'h1, exp_err}));
    if (!wr) chk(32'(rd), 32'(exp_rd));
  endtask

  task automatic wait_oe(input logic lvl, input int lim, output int cnt);
    cnt = 0;
    while (output_enable_out !== lvl && cnt < lim) begin
      @(negedge clk_in);
      cnt++;
    end
  endtask

  task automatic do_reset();
    reset_in = 1'h1;
    repeat (6) @(negedge clk_in);
    reset_in = 1'h0;
    repeat (3) @(negedge clk_in);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // watchdog: normal run is near 60000 cycles
  initial begin
    repeat (90000) @(posedge clk_in);
    miscompares++;
    close_out();
  end

  // ==========================================================================
  // tests
  // ==========================================================================
  initial begin
    reset_in = 1'h1;
    iin_meas_in = 16'h0000;
    miscompares = 0;
    num_checks = 0;
    void'($urandom(32'h2674_8d84));
    do_reset();
    reg_op(1'h0, UV_REACTION_ADDR, 16'h0000, 16'h0000, 1'h0);
    reg_op(1'h0, OC_THRESHOLD_ADDR, 16'h0000, 16'h07ff, 1'h0);
    reg_op(1'h0, EXPONENT_ADDR, 16'h0000, 16'h0000, 1'h0);
    reg_op(1'h1, 16'h0123, 16'hffff, 16'h0000, 1'h1);
    reg_op(1'h0, 16'h0123, 16'h0000, 16'h0000, 1'h1);
    chk(32'(output_enable_out), 32'h0000_0001);
    $display("test reset_and_map done");
    // field access: exponent mirrored, mantissa writable, top bits ignored on write
    for (int i = 0; i < 6; i++) begin
      w = 16'($urandom);
      x = 16'($urandom);
      reg_op(1'h1, EXPONENT_ADDR, x, 16'h0000, 1'h0);
      reg_op(1'h0, EXPONENT_ADDR, 16'h0000, x, 1'h0);
      reg_op(1'h1, OC_THRESHOLD_ADDR, w, 16'h0000, 1'h0);
      reg_op(1'h0, OC_THRESHOLD_ADDR, 16'h0000, {x[10:6], w[10:0]}, 1'h0);
      reg_op(1'h1, UV_REACTION_ADDR, w, 16'h0000, 1'h0);
      reg_op(1'h0, UV_REACTION_ADDR, 16'h0000, {8'h00, w[7:0]}, 1'h0);
    end
    $display("test register_fields done");
    // comparator: exponent extremes first, then boundary and random currents
    for (int i = 0; i < 24; i++) begin
      // corners: both extremes, then -1 on a just-over current and +1 on an exactly-equal one
      e = (i == 0) ? -16 : (i == 1) ? 15 : (i == 3) ? -1 : (i == 4) ? 1 : int'($urandom_range(9)) - 4;
      m = 11'($urandom);
      reg_op(1'h1, EXPONENT_ADDR, 16'(e & 31) << 6, 16'h0000, 1'h0);
      reg_op(1'h1, OC_THRESHOLD_ADDR, 16'(m), 16'h0000, 1'h0);
      bnd = (e >= 0) ? int'(32'(m) << e) : int'(32'(m) >> -e);
      meas = (i % 3 == 2) ? 16'($urandom) : 16'((bnd > 65534) ? 65534 : bnd) + 16'(i & 1);
      iin_meas_in = meas;
      @(posedge clk_in);
      @(negedge clk_in);
      chk(32'(oc_fault_out), 32'(exp_fault(meas, m, e)));
    end
    iin_meas_in = 16'h0000;
    $display("test comparator done");
    // sequencer after a mid-run reset; short fault must not drop the output
    do_reset();
    reg_op(1'h1, OC_THRESHOLD_ADDR, 16'h0064, 16'h0000, 1'h0);
    iin_meas_in = 16'h00c8;
    repeat (5) @(negedge clk_in);
    iin_meas_in = 16'h0000;
    wait_oe(1'h0, 100, n);
    chk_rng(n, 100, 100);
    for (int c = 0; c < 8; c++) begin
      reg_op(1'h1, UV_REACTION_ADDR, {8'h00, 5'($urandom), 3'(c)}, 16'h0000, 1'h0);
      iin_meas_in = 16'h00c8;
      wait_oe(1'h0, 20000, n);
      chk_rng(n, (10 << c) * CPM, (10 << c) * CPM + 10);
      iin_meas_in = 16'h0000;
      wait_oe(1'h1, 20000, n);
      chk_rng(n, int'(D2_TAB[c]) * CPM - 4, int'(D2_TAB[c]) * CPM + 10);
    end
    $display("test sequencer done");
    close_out();
  end
endmodule // testbench

`default_nettype wire
